// *** rtl/odl_pkg.sv ***
// Package for the octal converter serial loader.
// Assumes one system clock; every user writes odl_pkg::name.
package odl_pkg;
	// Serial word layout
	localparam int WORD_BITS    = 16;
	localparam int CODE_BITS    = 12;
	localparam int CODE_POS     = 4;
	localparam int ADDR_POS     = 3;
	localparam int SEL_POS      = 0;
	localparam int SEL_BITS     = 3;
	localparam int NUM_CHAN     = 8;
	localparam logic [4:0] LAST_BIT_CNT = 5'h0f;

	// Register byte offsets
	localparam logic [7:0] OFF_CTRL   = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_LAST   = 8'h08;
	localparam logic [7:0] OFF_DAC    = 8'h20;
	localparam logic [7:0] OFF_INPUT  = 8'h40;

	// Control field positions and reset value
	localparam int CTRL_HOLD_POS = 0;
	localparam logic CTRL_RESET  = 1'b0;

	// Status field positions
	localparam int ST_PEND_POS   = 0;
	localparam int ST_SHIFT_POS  = 1;
	localparam int ST_DONE_POS   = 2;
	localparam int ST_MISS_POS   = 3;
	localparam int ST_LEVEL_POS  = 8;

	// Latch reset value
	localparam logic [11:0] CODE_RESET = 12'h000;

	// Received word
	typedef struct packed {
		logic [11:0] code;
		logic        addr;
		logic [2:0]  sel;
	} odl_word_t;

	// Buffered latch write
	typedef struct packed {
		logic [2:0]  sel;
		logic [11:0] code;
	} odl_entry_t;

	// Frame sequencer states
	typedef enum logic [1:0] {
		ODL_IDLE  = 2'b00,
		ODL_SHIFT = 2'b01,
		ODL_DONE  = 2'b10
	} odl_state_t;
endpackage

// *** rtl/odl_loader.sv ***
// Serial loader for eight 12-bit converter channels, with its write FIFO.
// Assumes all pins are synchronous to clk_sys and the serial clock is slow
// enough that each level lasts at least one clk_sys cycle.
`timescale 1ns/1ps

module odl_fifo #(
	parameter int WIDTH = 15,
	parameter int DEPTH = 16
) (
	// Clock, reset, enable
	input  wire logic                     clk_sys,
	input  wire logic                     reset_n,
	input  wire logic                     clk_en,
	// Fill side
	input  wire logic [WIDTH-1:0]         in_data,
	input  wire logic                     in_valid,
	output      logic                     in_ready,
	// Drain side
	output      logic [WIDTH-1:0]         out_data,
	output      logic                     out_valid,
	input  wire logic                     out_ready,
	// Fill level
	output      logic [$clog2(DEPTH):0]   level
);
	localparam int AW = $clog2(DEPTH);

	// Refuse depths the pointer wrap cannot serve
	if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad
		$error("odl_fifo: DEPTH must be a power of two >= 2");
	end
	logic [WIDTH-1:0] mem [DEPTH];       // Storage words
	logic [AW-1:0]    wr_q, wr_d;        // Write pointer
	logic [AW-1:0]    rd_q, rd_d;        // Read pointer
	logic [AW:0]      cnt_q, cnt_d;      // Occupancy
	logic             push, pop;         // Accepted transfers
	// Handshake and pointer next values
	always_comb begin
		in_ready  = (cnt_q != (AW+1)'(DEPTH)); // Full only at the true depth
		out_valid = (cnt_q != '0);
		push      = in_valid && in_ready;
		pop       = out_valid && out_ready;
		wr_d      = push ? wr_q + 1'b1 : wr_q;
		rd_d      = pop ? rd_q + 1'b1 : rd_q;
		cnt_d     = cnt_q + (AW+1)'(push) - (AW+1)'(pop); // Push with pop cancels
	end
	// Pointer registers
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else if (clk_en) begin
			wr_q  <= wr_d;
			rd_q  <= rd_d;
			cnt_q <= cnt_d;
		end
	end
	// Storage write, no reset needed
	always_ff @(posedge clk_sys) begin
		if (clk_en && push) begin
			mem[wr_q] <= in_data;
		end
	end
	assign out_data = mem[rd_q];
	assign level    = cnt_q;
endmodule // odl_fifo

module odl_loader #(
	parameter int FIFO_DEPTH = 16
) (
	// Clock, reset, enable
	input  wire logic                    clk_sys,
	input  wire logic                    reset_n,
	input  wire logic                    clk_en,
	// Serial link
	input  wire logic                    serial_clock_in,
	input  wire logic                    frame_sync_n,
	input  wire logic                    serial_data_in,
	output      logic                    serial_data_out,
	// Strap and strobes
	input  wire logic                    device_address_strap,
	input  wire logic                    load_all_strobe_n,
	input  wire logic                    clear_outputs_n,
	// Converter latch codes, channel A in the low bits
	output      logic [8*12-1:0]         dac_code,
	// APB slave
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [7:0]              paddr,
	input  wire logic [31:0]             pwdata,
	input  wire logic [3:0]              pstrb,
	output      logic [31:0]             prdata,
	output      logic                    pready,
	output      logic                    pslverr
);
	localparam int NC = odl_pkg::NUM_CHAN;
	localparam int LW = $clog2(FIFO_DEPTH) + 1;

	if (FIFO_DEPTH < 2 || LW > 8) begin : g_bad
		$error("odl_loader: FIFO_DEPTH out of range");
	end
	// Channel window test, used for both latch banks
	function automatic logic in_bank(input logic [7:0] a, input logic [7:0] base);
		return (a[7:5] == base[7:5]) && (a[1:0] == 2'b00);
	endfunction
	// Serial sequencer state
	odl_pkg::odl_state_t st_q, st_d;     // Frame state
	logic [4:0]          cnt_q, cnt_d;   // Bits taken this frame
	logic [15:0]         sh_q, sh_d;     // Input shift register
	logic                sdo_q, sdo_d;   // Serial output flop
	logic                sck_q, fsn_q;   // Previous pin levels
	logic                pend_q, pend_d; // Word waiting for FIFO
	logic                miss_q, miss_d; // Last word had other address
	odl_pkg::odl_word_t  word_q, word_d; // Last complete word
	logic                sck_fall, sck_rise, fs_fall;
	odl_pkg::odl_word_t  rx;             // Word as completed now
	// FIFO link
	odl_pkg::odl_entry_t f_in, f_out;
	logic                f_in_ready, f_out_valid, f_out_ready;
	logic [LW-1:0]       f_level;
	// Latches and control
	logic [11:0] in_q [NC], in_d [NC];   // Input latches
	logic [11:0] dac_q [NC], dac_d [NC]; // Converter latches
	logic        hold_q, hold_d;         // Stall FIFO drain
	logic [31:0] rdata_q, rdata_d;       // Read data flop
	logic        err_q, err_d;           // Error flop
	logic        setup, wr_acc, mapped;
	// Serial frame sequencer next values
	always_comb begin
		sck_fall = sck_q && !serial_clock_in;
		sck_rise = !sck_q && serial_clock_in;
		fs_fall  = fsn_q && !frame_sync_n;
		st_d     = st_q;
		cnt_d    = cnt_q;
		sh_d     = sh_q;
		sdo_d    = sdo_q;
		pend_d   = pend_q;
		miss_d   = miss_q;
		word_d   = word_q;
		rx       = {sh_q[14:0], serial_data_in};
		// Pending word leaves once the FIFO takes it
		if (pend_q && f_in_ready) begin
			pend_d = 1'b0;
		end
		if (fs_fall) begin
			st_d  = odl_pkg::ODL_SHIFT;
			cnt_d = '0;
		end else if (st_q == odl_pkg::ODL_SHIFT) begin
			if (frame_sync_n) begin
				st_d = odl_pkg::ODL_IDLE;
			// sample on falling edge, stall while word waits
			end else if (sck_fall && !pend_q) begin
				sh_d  = rx;
				cnt_d = cnt_q + 1'b1;
				if (cnt_q == odl_pkg::LAST_BIT_CNT) begin
					st_d   = odl_pkg::ODL_DONE;
					word_d = rx;
					miss_d = (rx.addr != device_address_strap);
					pend_d = (rx.addr == device_address_strap);
				end
			end
		end
		if (sck_rise) begin
			sdo_d = sh_q[odl_pkg::WORD_BITS-1];
		end
	end

	// code and select fields into FIFO
	assign f_in = '{sel: word_q.sel, code: word_q.code};
	// Serial sequencer registers
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			st_q   <= odl_pkg::ODL_IDLE;
			cnt_q  <= '0;
			sh_q   <= '0;
			sdo_q  <= 1'b0;
			sck_q  <= 1'b0;
			fsn_q  <= 1'b1;
			pend_q <= 1'b0;
			miss_q <= 1'b0;
			word_q <= '0;
		end else if (clk_en) begin
			st_q   <= st_d;
			cnt_q  <= cnt_d;
			sh_q   <= sh_d;
			sdo_q  <= sdo_d;
			sck_q  <= serial_clock_in;
			fsn_q  <= frame_sync_n;
			pend_q <= pend_d;
			miss_q <= miss_d;
			word_q <= word_d;
		end
	end

	assign serial_data_out = sdo_q;
	// Word buffer between link and input latches
	odl_fifo #(.WIDTH($bits(odl_pkg::odl_entry_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk_sys   (clk_sys),
		.reset_n   (reset_n),
		.clk_en    (clk_en),
		.in_data   (f_in),
		.in_valid  (pend_q),
		.in_ready  (f_in_ready),
		.out_data  (f_out),
		.out_valid (f_out_valid),
		.out_ready (f_out_ready),
		.level     (f_level)
	);

	assign f_out_ready = !hold_q;

	// Latch next values
	always_comb begin
		for (int i = 0; i < NC; i++) begin
			in_d[i] = in_q[i];
			if (f_out_valid && f_out_ready && f_out.sel == 3'(i)) begin
				in_d[i] = f_out.code;
			end
			if (!clear_outputs_n) begin
				dac_d[i] = odl_pkg::CODE_RESET;
			// load strobe copies all channels at once
			end else if (!load_all_strobe_n) begin
				dac_d[i] = in_q[i];
			end else begin
				dac_d[i] = dac_q[i];
			end
		end
	end

	// Latch registers
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < NC; i++) begin
				in_q[i]  <= odl_pkg::CODE_RESET;
				dac_q[i] <= odl_pkg::CODE_RESET;
			end
		end else if (clk_en) begin
			for (int i = 0; i < NC; i++) begin
				in_q[i]  <= in_d[i];
				dac_q[i] <= dac_d[i];
			end
		end
	end

	// Flatten converter codes
	for (genvar g = 0; g < NC; g++) begin : g_out
		assign dac_code[g*12 +: 12] = dac_q[g];
	end

	// APB decode, read capture and control write
	always_comb begin
		setup   = psel && !penable;
		wr_acc  = psel && penable && pwrite;
		mapped  = (paddr == odl_pkg::OFF_CTRL) || (paddr == odl_pkg::OFF_STATUS)
			|| (paddr == odl_pkg::OFF_LAST) || in_bank(paddr, odl_pkg::OFF_DAC)
			|| in_bank(paddr, odl_pkg::OFF_INPUT);
		rdata_d = rdata_q;
		err_d   = err_q;
		hold_d  = hold_q;
		if (setup) begin
			rdata_d = '0;
			// Only the control word is writable
			err_d   = !mapped || (pwrite && paddr != odl_pkg::OFF_CTRL);
			if (!pwrite) begin
				if (paddr == odl_pkg::OFF_CTRL) begin
					rdata_d[odl_pkg::CTRL_HOLD_POS] = hold_q;
				end else if (paddr == odl_pkg::OFF_STATUS) begin
					rdata_d[odl_pkg::ST_PEND_POS]  = pend_q;
					rdata_d[odl_pkg::ST_SHIFT_POS] = (st_q == odl_pkg::ODL_SHIFT);
					rdata_d[odl_pkg::ST_DONE_POS]  = (st_q == odl_pkg::ODL_DONE);
					rdata_d[odl_pkg::ST_MISS_POS]  = miss_q;
					rdata_d[odl_pkg::ST_LEVEL_POS +: LW] = f_level;
				end else if (paddr == odl_pkg::OFF_LAST) begin
					rdata_d[15:0] = word_q;
				end else if (in_bank(paddr, odl_pkg::OFF_DAC)) begin
					rdata_d[11:0] = dac_q[paddr[4:2]];
				end else if (in_bank(paddr, odl_pkg::OFF_INPUT)) begin
					rdata_d[11:0] = in_q[paddr[4:2]];
				end
			end
		end
		// Write lands at the access edge
		if (wr_acc && paddr == odl_pkg::OFF_CTRL && pstrb[0]) begin
			hold_d = pwdata[odl_pkg::CTRL_HOLD_POS];
		end
	end

	// APB registers
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			rdata_q <= '0;
			err_q   <= 1'b0;
			hold_q  <= odl_pkg::CTRL_RESET;
		end else if (clk_en) begin
			rdata_q <= rdata_d;
			err_q   <= err_d;
			hold_q  <= hold_d;
		end
	end

	// Zero-wait answer in every access phase
	assign pready  = psel && penable;
	assign prdata  = rdata_q;
	assign pslverr = psel && penable && err_q;
endmodule // odl_loader

// *** tb/odl_monitor.sv ***
// Port checker for the serial loader.
// Assumes clk_en held high by the bench.
`timescale 1ns/1ps
module odl_monitor (
	// Clock and reset
	input wire logic        clk_sys,
	input wire logic        reset_n,
	// Serial and strobes
	input wire logic        serial_clock_in,
	input wire logic        serial_data_out,
	input wire logic        load_all_strobe_n,
	input wire logic        clear_outputs_n,
	input wire logic [95:0] dac_code,
	// APB
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic        pready,
	input wire logic        pslverr
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	// Strobe states and serial rises
	sequence s_idle; load_all_strobe_n && clear_outputs_n; endsequence
	sequence s_clr2; !clear_outputs_n ##1 !clear_outputs_n; endsequence
	sequence s_both2; (!clear_outputs_n && !load_all_strobe_n)[*2]; endsequence
	sequence s_rise; $past(serial_clock_in) && !$past(serial_clock_in, 2); endsequence
	sequence s_rise2; $past(serial_clock_in, 2) && !$past(serial_clock_in, 3); endsequence
	sequence s_setup; psel && !penable; endsequence
	property p_clear; s_clr2 |-> dac_code == '0; endproperty
	property p_both; s_both2 |-> dac_code == '0; endproperty
	property p_hold; s_idle |=> $stable(dac_code); endproperty
	property p_sdo; $changed(serial_data_out) |-> s_rise or s_rise2; endproperty
	property p_setup; s_setup |-> !pready && !pslverr; endproperty
	property p_wait; s_setup ##1 psel && penable |-> pready; endproperty
	property p_rderr; psel && penable && paddr == 8'h0c |-> pslverr; endproperty
	property p_wrerr; psel && penable && pwrite && paddr != 8'h00 |-> pslverr; endproperty
	a_clear: assert property (p_clear) else $error("dac not cleared");
	a_both: assert property (p_both) else $error("clear lost to load");
	a_hold: assert property (p_hold) else $error("dac moved");
	a_sdo: assert property (p_sdo) else $error("sdo moved off rise");
	a_setup: assert property (p_setup) else $error("early ready"); // setup
	a_wait: assert property (p_wait) else $error("wait state"); // access
	a_rderr: assert property (p_rderr) else $error("no read error"); // unmapped
	a_wrerr: assert property (p_wrerr) else $error("no write error"); // read only
endmodule // odl_monitor

// *** tb/odl_host_model.sv ***
// Host side of the serial link.
// Assumes the bench calls send after a clock edge.
`timescale 1ns/1ps
module odl_host_model #(
	parameter int HALF = 3    // Cycles per serial level
) (
	// Clock
	input  wire logic clk_sys,
	// Serial link
	output      logic serial_clock_in,
	output      logic frame_sync_n,
	output      logic serial_data_in,
	input  wire logic serial_data_out
);
	// Idle link
	initial begin
		serial_clock_in = 1'b0;
		frame_sync_n = 1'b1;
		serial_data_in = 1'b0;
	end
	// Send n bits, collect the daisy output
	task automatic send(input logic [15:0] w, input int n, output logic [15:0] rx);
		rx = '0;
		frame_sync_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		for (int i = 0; i < n; i++) begin
			serial_data_in <= (i < 16) ? w[15 - i] : ~w[0];
			serial_clock_in <= 1'b1;
			repeat (HALF) @(posedge clk_sys);
			if (i < 16) rx[15 - i] = serial_data_out;
			serial_clock_in <= 1'b0;
			repeat (HALF) @(posedge clk_sys);
		end
		frame_sync_n <= 1'b1;
		serial_data_in <= ~serial_data_in;
		repeat (4) @(posedge clk_sys);
	endtask
endmodule // odl_host_model

// *** tb/odl_loader_tb.sv ***
// Bench: host model, APB master, latch model.
// Assumes clk_en high throughout.
`timescale 1ns/1ps
module odl_loader_tb;
	logic        clk_sys = 1'b0;   // Clock
	logic        reset_n = 1'b0;   // Reset
	logic        strap   = 1'b0;   // Address strap
	logic        ld_n    = 1'b1;   // Load strobe
	logic        clr_n   = 1'b1;   // Clear strobe
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
	logic [7:0]  paddr   = 8'h00;
	logic [31:0] pwdata  = 32'h0, prdata, rd;
	logic        pready, pslverr, sclk, fsn, sdi, sdo;
	logic [95:0] dac_code;
	logic [15:0] w, rx;
	int          seed = 21, miscompares = 0, n_checks = 0, cyc = 0, ret = 0, t = 0;
	int          exp_in [8] = '{default: 0};   // Input latch model
	always #50 clk_sys = ~clk_sys;
	odl_loader #(.FIFO_DEPTH(16)) uut (
		.clk_sys(clk_sys), .reset_n(reset_n), .clk_en(1'b1),
		.serial_clock_in(sclk), .frame_sync_n(fsn), .serial_data_in(sdi),
		.serial_data_out(sdo), .device_address_strap(strap),
		.load_all_strobe_n(ld_n), .clear_outputs_n(clr_n), .dac_code(dac_code),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(4'h1), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));
	odl_host_model host (.clk_sys(clk_sys), .serial_clock_in(sclk),
		.frame_sync_n(fsn), .serial_data_in(sdi), .serial_data_out(sdo));
	// Compare and count
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	// One APB transfer
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		@(posedge clk_sys);
		while (pready !== 1'b1) @(posedge clk_sys);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Send a word, update models
	task automatic word(input int ch, input logic a, input int n);
		int m;
		w = {12'($random(seed)), a, 3'(ch)};
		host.send(w, n, rx);
		// Only the first bits of a cut frame are collected
		m = (n < 16) ? n : 16;
		chk("daisy", 32'(ret) >> (16 - m), 32'(rx) >> (16 - m));
		if (n >= 16) begin
			ret = w;
			if (a == strap) exp_in[ch] = w[15:4];
			apb(1'b0, odl_pkg::OFF_LAST, 32'h0);
			chk("last word", 32'(w), rd);
		end else ret = ((ret << n) | (w >> (16 - n))) & 16'hffff;
	endtask
	// Input latches against model
	task automatic chk_in();
		for (int i = 0; i < 8; i++) begin
			apb(1'b0, odl_pkg::OFF_INPUT + 8'(4 * i), 32'h0);
			chk("input latch", 32'(exp_in[i]), rd);
		end
	endtask
	// Converter codes against model
	task automatic chk_dac(input logic z);
		for (int i = 0; i < 8; i++) begin
			chk("dac", z ? 32'h0 : 32'(exp_in[i]), 32'(dac_code[12*i +: 12]));
			apb(1'b0, odl_pkg::OFF_DAC + 8'(4 * i), 32'h0);
			chk("dac reg", z ? 32'h0 : 32'(exp_in[i]), rd);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Hang guard
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 30000) begin
			miscompares++;
			end_of_test();
		end
	end
	initial begin
		repeat (12) @(posedge clk_sys);
		reset_n <= 1'b1;
		apb(1'b0, odl_pkg::OFF_CTRL, 32'h0);
		chk("ctrl reset", 32'h0, rd);
		apb(1'b0, 8'h0c, 32'h0);
		chk("unmapped", 32'h1, 32'(err));
		apb(1'b1, odl_pkg::OFF_STATUS, 32'h1);
		chk("ro write", 32'h1, 32'(err));
		// All channels, both straps, random address bit
		for (int k = 0; k < 16; k++) begin
			if (k == 8) strap <= 1'b1;
			word(k % 8, 1'($random(seed)), 16);
		end
		word(3, strap, 20);
		word(5, strap, 9);
		word(6, strap, 16);
		chk_in();
		// Fill the buffer with drain held, one more pending
		apb(1'b1, odl_pkg::OFF_CTRL, 32'h1);
		for (int k = 0; k < 17; k++) word(k % 8, strap, 16);
		apb(1'b0, odl_pkg::OFF_STATUS, 32'h0);
		chk("fifo level", 32'h10, 32'(rd[12:8]));
		chk("pending", 32'h1, rd & 32'h1);
		apb(1'b1, odl_pkg::OFF_CTRL, 32'h0);
		do apb(1'b0, odl_pkg::OFF_STATUS, 32'h0);
		while ((rd & 32'h1f01) !== 32'h0 && ++t < 40);
		chk("drained", 32'h0, rd & 32'h1f01);
		chk_in();
		// Load, clear with load, clear, reload
		ld_n <= 1'b0;
		repeat (3) @(posedge clk_sys);
		chk_dac(1'b0);
		clr_n <= 1'b0;
		repeat (3) @(posedge clk_sys);
		chk_dac(1'b1);
		ld_n <= 1'b1;
		repeat (3) @(posedge clk_sys);
		chk_dac(1'b1);
		clr_n <= 1'b1;
		ld_n <= 1'b0;
		repeat (3) @(posedge clk_sys);
		chk_dac(1'b0);
		end_of_test();
	end
endmodule // odl_loader_tb
bind odl_loader odl_monitor mon (.clk_sys(clk_sys), .reset_n(reset_n),
	.serial_clock_in(serial_clock_in), .serial_data_out(serial_data_out),
	.load_all_strobe_n(load_all_strobe_n), .clear_outputs_n(clear_outputs_n),
	.dac_code(dac_code), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pready(pready), .pslverr(pslverr));
